// File: lsd_diag_status.sv
// Diagnostic status logic of a three-channel LED buck driver, reached over the serial link.
// Assumes analog status lines and pins are asynchronous; temp_code_in and diag2_in share the clock.
import lsd_pkg::*;

module lsd_diag_status #(
  parameter int STARTUP_ERR_CYCLES = `LSD_T_ERR_STARTUP_US * `LSD_CLK_MHZ,
  parameter int OPER_ERR_CYCLES    = `LSD_T_ERR_OPER_US * `LSD_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                reset_in,
  // Serial link pins
  input  wire logic                spi_sclk_in,
  input  wire logic                spi_cs_n_in,
  input  wire logic                spi_mosi_in,
  output logic                     spi_miso_out,
  output logic                     spi_miso_oe_out,
  // Analog status pins
  input  wire logic                supply_above_uv_in,
  input  wire logic                overtemp_in,
  input  wire logic                gate_supply_at_target_in,
  input  wire logic                enable_in,
  input  wire lsd_pkg::lsd_chan_t  chan_in,
  // Same-clock data from neighbouring logic
  input  wire logic [7:0]          temp_code_in,
  input  wire logic [7:0]          diag2_in,
  // Power stage control
  output logic                     regulator_enable_out,
  output logic                     gate_switch_enable_out,
  output logic [2:0]               current_enable_out,
  output logic                     led_voltage_sample_update_out,
  output logic                     diag2_write_out
);
  import lsd_pkg::*;

  localparam logic [`LSD_ERR_CNT_BITS-1:0] STARTUP_LIM = `LSD_ERR_CNT_BITS'(STARTUP_ERR_CYCLES);
  localparam logic [`LSD_ERR_CNT_BITS-1:0] OPER_LIM    = `LSD_ERR_CNT_BITS'(OPER_ERR_CYCLES);

  // Address classes
  function automatic logic addr_readable(input logic [6:0] a);
    if (a == `LSD_ADDR_FCTRL || a == `LSD_ADDR_COPY || a == `LSD_ADDR_TEMP) begin
      return 1'b1;
    end else if (a == `LSD_ADDR_DIAG2 || a == `LSD_ADDR_DIAG1) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic addr_writable(input logic [6:0] a);
    if (a == `LSD_ADDR_FCTRL || a == `LSD_ADDR_COPY) begin
      return 1'b1;
    end else if (a == `LSD_ADDR_DIAG2 || a == `LSD_ADDR_DIAG1) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // Synchronised pins
  logic [12:0] pin_meta;
  logic [12:0] pin_sync;
  logic        supply_ok_flag;
  logic        ot_s;
  logic        at_target_s;
  logic        enable_s;
  lsd_chan_t   chan_s;

  // Link state
  lsd_frame_t      frame;
  logic            frame_done;
  logic            frame_bad;
  logic            err_event;
  logic            good_wr;
  logic            wr_diag1;
  logic [7:0]      rd_data;
  logic [7:0]      diag1;
  logic [15:0]     reply;
  logic [15:0]     next_reply;
  lsd_reply_kind_t reply_kind;
  lsd_reply_kind_t next_reply_kind;
  logic            link_fault;
  logic            next_link_fault;
  logic [2:0]      pwm_ctrl;
  logic [2:0]      next_pwm_ctrl;
  logic            clr_req;
  logic            next_clr_req;
  logic [2:0]      copy_req;
  logic [2:0]      next_copy_req;
  logic            diag2_wr;
  logic            next_diag2_wr;

  // Fault state
  logic overtemp_flag;
  logic next_overtemp_flag;
  logic gate_supply_fault;
  logic next_gate_supply_fault;
  logic fault_with_ot;
  logic next_fault_with_ot;
  logic gate_supply_good;
  logic next_gate_supply_good;
  logic ever_good;
  logic next_ever_good;
  logic regulator_on;
  logic timer_expired;

  // Channel state
  logic [2:0] pwm_prev;
  logic [2:0] live_reached_flag;
  logic [2:0] next_live_reached_flag;
  logic [2:0] current_hit;
  logic [2:0] next_current_hit;
  logic [2:0] pwm_fall;

  // Two flops on every asynchronous status line
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_meta <= 13'h0000;
      pin_sync <= 13'h0000;
    end else begin
      pin_meta <= {supply_above_uv_in, overtemp_in, gate_supply_at_target_in, enable_in, chan_in};
      pin_sync <= pin_meta;
    end
  end

  assign supply_ok_flag = pin_sync[12];
  assign ot_s           = pin_sync[11];
  assign at_target_s    = pin_sync[10];
  assign enable_s       = pin_sync[9];
  assign chan_s         = pin_sync[8:0];

  // Serial engine
  lsd_spi_slave #(
    .FRAME_BITS (`LSD_FRAME_BITS)
  ) u_spi (
    .core_clk_in     (core_clk_in),
    .reset_in        (reset_in),
    .spi_sclk_in     (spi_sclk_in),
    .spi_cs_n_in     (spi_cs_n_in),
    .spi_mosi_in     (spi_mosi_in),
    .spi_miso_out    (spi_miso_out),
    .spi_miso_oe_out (spi_miso_oe_out),
    .reply_in        (reply),
    .frame_out       (frame),
    .frame_done_out  (frame_done),
    .frame_bad_out   (frame_bad)
  );

  // Access checks: any bad access raises the flag and is not executed
  assign err_event = frame_done && (frame_bad ||
                     (frame.wr && !addr_writable(frame.addr)) ||
                     (!frame.wr && !addr_readable(frame.addr)));
  assign good_wr   = frame_done && !err_event && frame.wr;
  assign wr_diag1  = good_wr && (frame.addr == `LSD_ADDR_DIAG1);

  assign diag1 = {supply_ok_flag, link_fault, overtemp_flag, gate_supply_fault,
                  gate_supply_good, current_hit};

  // Read data mux
  always_comb begin
    rd_data = 8'h00;
    if (frame.addr == `LSD_ADDR_FCTRL) begin
      rd_data = {1'b1, clr_req, 2'h0, pwm_ctrl, 1'b0};
    end else if (frame.addr == `LSD_ADDR_COPY) begin
      rd_data = {5'h00, copy_req};
    end else if (frame.addr == `LSD_ADDR_TEMP) begin
      rd_data = temp_code_in;
    end else if (frame.addr == `LSD_ADDR_DIAG2) begin
      rd_data = diag2_in;
    end else if (frame.addr == `LSD_ADDR_DIAG1) begin
      rd_data = diag1;
    end
  end

  // Register writes, reply preparation and link-fault flag
  always_comb begin
    next_pwm_ctrl   = pwm_ctrl;
    next_clr_req    = 1'b0;
    next_copy_req   = 3'h0;
    next_diag2_wr   = 1'b0;
    next_reply      = reply;
    next_reply_kind = reply_kind;
    if (good_wr && frame.addr == `LSD_ADDR_FCTRL) begin
      next_pwm_ctrl = frame.data[`LSD_FCTRL_PWM_LSB +: 3];
      next_clr_req  = frame.data[`LSD_FCTRL_CLR_BIT];
    end
    if (good_wr && frame.addr == `LSD_ADDR_COPY) begin
      next_copy_req = frame.data[2:0];
    end
    if (good_wr && frame.addr == `LSD_ADDR_DIAG2) begin
      next_diag2_wr = 1'b1;
    end
    if (err_event) begin
      next_reply      = {diag1 | 8'h40, diag2_in};
      next_reply_kind = LSD_REPLY_ERROR;
    end else if (frame_done) begin
      next_reply      = {diag1, rd_data};
      next_reply_kind = LSD_REPLY_NORMAL;
    end
    // A new error wins over a clearing write in the same cycle
    next_link_fault = err_event || (link_fault && !wr_diag1);
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pwm_ctrl   <= `LSD_FCTRL_PWM_RESET;
      clr_req    <= 1'b0;
      copy_req   <= 3'h0;
      diag2_wr   <= 1'b0;
      reply      <= 16'h0000;
      reply_kind <= LSD_REPLY_NORMAL;
      link_fault <= 1'b0;
    end else begin
      pwm_ctrl   <= next_pwm_ctrl;
      clr_req    <= next_clr_req;
      copy_req   <= next_copy_req;
      diag2_wr   <= next_diag2_wr;
      reply      <= next_reply;
      reply_kind <= next_reply_kind;
      link_fault <= next_link_fault;
    end
  end

  // Gate supply regulator runs only with supply, enable and no latched fault
  assign regulator_on = supply_ok_flag && enable_s && !overtemp_flag && !gate_supply_fault;

  // Start-up delay applies until the gate supply has been good since enable and supply last came up
  lsd_fault_timer #(
    .W (`LSD_ERR_CNT_BITS)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .run_in      (regulator_on && !at_target_s),
    .limit_in    (ever_good ? OPER_LIM : STARTUP_LIM),
    .expired_out (timer_expired)
  );

  // Fault flags; sets win over clears so no event is lost
  always_comb begin
    next_overtemp_flag = ot_s || (overtemp_flag && !clr_req);
    next_fault_with_ot = fault_with_ot;
    next_gate_supply_fault = gate_supply_fault;
    if (clr_req || !enable_s) begin
      next_gate_supply_fault = 1'b0;
      next_fault_with_ot     = 1'b0;
    end
    if (timer_expired) begin
      next_gate_supply_fault = 1'b1;
    end
    if (ot_s && !overtemp_flag && gate_supply_good) begin
      next_gate_supply_fault = 1'b1;
      next_fault_with_ot     = 1'b1;
    end
    if (overtemp_flag && !next_overtemp_flag && fault_with_ot && !timer_expired) begin
      next_gate_supply_fault = 1'b0;
      next_fault_with_ot     = 1'b0;
    end
    // Good only while regulating; any undervoltage or fault drops it
    next_gate_supply_good = regulator_on && !ot_s && !timer_expired &&
                            (gate_supply_good || at_target_s);
    next_ever_good = enable_s && supply_ok_flag && (ever_good || gate_supply_good);
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      overtemp_flag     <= 1'b0;
      gate_supply_fault <= 1'b0;
      fault_with_ot     <= 1'b0;
      gate_supply_good  <= 1'b0;
      ever_good         <= 1'b0;
    end else begin
      overtemp_flag     <= next_overtemp_flag;
      gate_supply_fault <= next_gate_supply_fault;
      fault_with_ot     <= next_fault_with_ot;
      gate_supply_good  <= next_gate_supply_good;
      ever_good         <= next_ever_good;
    end
  end

  assign pwm_fall = pwm_prev & ~chan_s.pwm;

  // Live reached and latched hit bits per channel
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_live_reached_flag[i] = live_reached_flag[i];
      next_current_hit[i]       = current_hit[i];
      if (!supply_ok_flag || pwm_fall[i] || copy_req[i]) begin
        next_live_reached_flag[i] = 1'b0;
      end
      if (chan_s.reached[i] && current_enable_out[i]) begin
        next_live_reached_flag[i] = 1'b1;
      end
      if (pwm_fall[i] || copy_req[i]) begin
        next_current_hit[i] = live_reached_flag[i];
      end
      if (!supply_ok_flag || chan_s.headroom_low[i]) begin
        next_current_hit[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pwm_prev          <= 3'h0;
      live_reached_flag <= 3'h0;
      current_hit       <= 3'h0;
    end else begin
      pwm_prev          <= chan_s.pwm;
      live_reached_flag <= next_live_reached_flag;
      current_hit       <= next_current_hit;
    end
  end

  // Power stage enables
  assign regulator_enable_out          = regulator_on;
  assign gate_switch_enable_out        = regulator_on && gate_supply_good;
  assign current_enable_out            = {3{gate_switch_enable_out}} & chan_s.pwm & pwm_ctrl;
  assign led_voltage_sample_update_out = supply_ok_flag && gate_supply_good;
  assign diag2_write_out               = diag2_wr;

endmodule // lsd_diag_status

// File: lsd_regs.svh
// Register offsets, field positions, reset values and timing for the LED driver diagnostic block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

// Register offsets (7-bit address field of the serial frame)
`define LSD_ADDR_FCTRL       7'h00
`define LSD_ADDR_COPY        7'h06
`define LSD_ADDR_TEMP        7'h26
`define LSD_ADDR_DIAG2       7'h36
`define LSD_ADDR_DIAG1       7'h37

// Function control fields
`define LSD_FCTRL_STATUS_BIT 7
`define LSD_FCTRL_CLR_BIT    6
`define LSD_FCTRL_PWM_LSB    1
`define LSD_FCTRL_PWM_RESET  3'h7

// Operational status field positions
`define LSD_D1_SUPPLY_OK     7
`define LSD_D1_LINK_FAULT    6
`define LSD_D1_OVERTEMP      5
`define LSD_D1_GATE_FAULT    4
`define LSD_D1_GATE_GOOD     3

// Serial frame and timing
`define LSD_FRAME_BITS       16
`define LSD_CLK_MHZ          25
`define LSD_T_ERR_STARTUP_US 1000
`define LSD_T_ERR_OPER_US    100
`define LSD_ERR_CNT_BITS     16

`endif

// File: lsd_pkg.sv
// Types shared by the LED driver diagnostic block.
// Assumes lsd_regs.svh is on the include path.
`include "lsd_regs.svh"

package lsd_pkg;

  // One serial frame: write flag, address, data
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } lsd_frame_t;

  // Per-channel pin group
  typedef struct packed {
    logic [2:0] pwm;
    logic [2:0] reached;
    logic [2:0] headroom_low;
  } lsd_chan_t;

  // What the next frame returns
  typedef enum logic {LSD_REPLY_NORMAL, LSD_REPLY_ERROR} lsd_reply_kind_t;

endpackage : lsd_pkg

// File: lsd_fault_timer.sv
// Error delay counter for the gate drive supply.
// Assumes run_in and limit_in come from logic on the same clock.
module lsd_fault_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  // Control
  input  wire logic         run_in,
  input  wire logic [W-1:0] limit_in,
  // Status
  output logic              expired_out
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Count while out of regulation, saturate at the limit
  always_comb begin
    if (!run_in) begin
      next_count = '0;
    end else if (count >= limit_in) begin
      next_count = count;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Level while the delay has run out and the supply is still missing
  assign expired_out = run_in && (count >= limit_in);

endmodule // lsd_fault_timer

// File: lsd_spi_slave.sv
// Serial slave shift engine: synchronises the pins, collects one frame, shifts the reply.
// Assumes mode 0 and a serial clock well below an eighth of core_clk_in.
import lsd_pkg::*;

module lsd_spi_slave #(
  parameter int FRAME_BITS = `LSD_FRAME_BITS
) (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              reset_in,
  // Serial pins
  input  wire logic              spi_sclk_in,
  input  wire logic              spi_cs_n_in,
  input  wire logic              spi_mosi_in,
  output logic                   spi_miso_out,
  output logic                   spi_miso_oe_out,
  // Frame side
  input  wire logic [15:0]       reply_in,
  output lsd_pkg::lsd_frame_t    frame_out,
  output logic                   frame_done_out,
  output logic                   frame_bad_out
);
  import lsd_pkg::*;

  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic        sclk_prev;
  logic        cs_prev;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [3:0]  bit_cnt;
  logic        seen;
  logic [15:0] next_shift_in;
  logic [15:0] next_shift_out;
  logic [3:0]  next_bit_cnt;
  logic        next_seen;
  logic        sclk_s;
  logic        cs_s;
  logic        sclk_rise;
  logic        sclk_fall;

  // Two flops on every pin before anything looks at them
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      // Idle levels (chip select high, clock low) so reset shows no false frame
      pin_meta  <= 3'h4;
      pin_sync  <= 3'h4;
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;
    end else begin
      pin_meta  <= {spi_cs_n_in, spi_sclk_in, spi_mosi_in};
      pin_sync  <= pin_meta;
      sclk_prev <= pin_sync[1];
      cs_prev   <= pin_sync[2];
    end
  end

  assign sclk_s    = pin_sync[1];
  assign cs_s      = pin_sync[2];
  assign sclk_rise = sclk_s && !sclk_prev && !cs_s;
  assign sclk_fall = !sclk_s && sclk_prev && !cs_s;

  // Shift and count; only the low four bits matter for the frame check
  always_comb begin
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_bit_cnt   = bit_cnt;
    next_seen      = seen;
    if (cs_prev && !cs_s) begin
      next_shift_out = reply_in;
      next_bit_cnt   = 4'h0;
      next_seen      = 1'b0;
    end else begin
      if (sclk_rise) begin
        next_shift_in = {shift_in[14:0], pin_sync[0]};
        next_bit_cnt  = bit_cnt + 4'h1;
        next_seen     = 1'b1;
      end
      if (sclk_fall) begin
        next_shift_out = {shift_out[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      shift_in  <= 16'h0000;
      shift_out <= 16'h0000;
      bit_cnt   <= 4'h0;
      seen      <= 1'b0;
    end else begin
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      bit_cnt   <= next_bit_cnt;
      seen      <= next_seen;
    end
  end

  // Frame ends when chip select returns high
  assign frame_done_out  = cs_s && !cs_prev;
  assign frame_bad_out   = !seen || (bit_cnt != 4'h0);
  assign frame_out       = shift_in;
  assign spi_miso_out    = shift_out[15];
  assign spi_miso_oe_out = !cs_s;

endmodule // lsd_spi_slave

// File: lsd_diag_props.sv
// Checker for the power stage outputs of the diagnostic status block.
// Assumes it is bound to lsd_diag_status and sees only its ports.
module lsd_diag_props #(
  parameter int STARTUP_ERR_CYCLES = 20,
  parameter int OPER_ERR_CYCLES    = 5
) (
  // Clock, reset and status pins
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic       spi_cs_n_in,
  input wire logic       supply_above_uv_in,
  input wire logic       overtemp_in,
  input wire logic       gate_supply_at_target_in,
  input wire logic       enable_in,
  // Power stage control
  input wire logic       regulator_enable_out,
  input wire logic       gate_switch_enable_out,
  input wire logic [2:0] current_enable_out,
  input wire logic       led_voltage_sample_update_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Margin covers the pin synchronisers
  localparam int LIMIT = STARTUP_ERR_CYCLES + 4;
  logic [15:0] wait_cnt;
  logic [15:0] next_wait;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  // Cycles the regulator runs without reaching its target
  always_comb begin
    next_wait = wait_cnt + 16'h0001;
    if (!regulator_enable_out || gate_supply_at_target_in) next_wait = 16'h0000;
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) wait_cnt <= 16'h0000;
    else wait_cnt <= next_wait;
  end

  // Hot, with no frame that could carry a clear command
  sequence s_hot_quiet;
    (overtemp_in && spi_cs_n_in) [*4] ##1 spi_cs_n_in [*8];
  endsequence
  sequence s_supply_low;
    !supply_above_uv_in [*5];
  endsequence

  a_supply_low_off: assert property (s_supply_low |-> !regulator_enable_out && !led_voltage_sample_update_out
    && current_enable_out == 3'h0) else $error("power stage active under undervoltage");
  a_current_needs_gate: assert property (|current_enable_out |-> gate_switch_enable_out)
    else $error("current enabled without gate switching");
  a_sample_needs_supply: assert property (led_voltage_sample_update_out |->
    $past(supply_above_uv_in, 2) || $past(supply_above_uv_in, 3)) else $error("sample updated on low supply");
  a_overtemp_shutdown: assert property (overtemp_in [*5] |-> !regulator_enable_out && current_enable_out == 3'h0)
    else $error("power stage active while hot");
  a_fault_holds: assert property (s_hot_quiet |-> !regulator_enable_out && !gate_switch_enable_out)
    else $error("overtemp shutdown released without clear");
  a_gate_fault_delay: assert property (wait_cnt <= LIMIT)
    else $error("gate supply fault not raised in time");
  a_gate_after_reg: assert property (gate_switch_enable_out |-> regulator_enable_out)
    else $error("gates switch with regulator off");
  a_off_mode: assert property (!enable_in [*5] |-> !regulator_enable_out)
    else $error("regulator on in off mode");
endmodule // lsd_diag_props

bind lsd_diag_status lsd_diag_props #(
  .STARTUP_ERR_CYCLES(STARTUP_ERR_CYCLES),
  .OPER_ERR_CYCLES   (OPER_ERR_CYCLES)
) u_props (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .spi_cs_n_in(spi_cs_n_in),
  .supply_above_uv_in(supply_above_uv_in), .overtemp_in(overtemp_in),
  .gate_supply_at_target_in(gate_supply_at_target_in), .enable_in(enable_in),
  .regulator_enable_out(regulator_enable_out), .gate_switch_enable_out(gate_switch_enable_out),
  .current_enable_out(current_enable_out), .led_voltage_sample_update_out(led_voltage_sample_update_out)
);

// File: lsd_mcu_model.sv
// Serial controller model: mode 0 master framing words and collecting replies.
// Assumes pacing from the core clock; pins change only at its falling edge.
module lsd_mcu_model #(
  parameter int HALF = 8
) (
  input  wire logic core_clk_in,
  input  wire logic spi_miso_in,
  input  wire logic spi_miso_oe_in,
  output logic      spi_sclk_out,
  output logic      spi_cs_n_out,
  output logic      spi_mosi_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock idles low between frames
  initial begin
    spi_sclk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end

  // One frame, MSB first; an undriven reply line reads as unknown
  task automatic xfer(input logic [31:0] word, input int nbits, output logic [15:0] reply);
    reply = 16'h0000;
    @(negedge core_clk_in);
    spi_cs_n_out = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_mosi_out = word[i];
      repeat (HALF) @(negedge core_clk_in);
      spi_sclk_out = 1'b1;
      reply = {reply[14:0], spi_miso_oe_in ? spi_miso_in : 1'bx};
      repeat (HALF) @(negedge core_clk_in);
      spi_sclk_out = 1'b0;
    end
    repeat (HALF) @(negedge core_clk_in);
    spi_cs_n_out = 1'b1;
    // Gap lets the frame execute before the next one
    repeat (2 * HALF) @(negedge core_clk_in);
  endtask
endmodule // lsd_mcu_model

// File: tb_lsd_diag_status.sv
// Self-checking bench for the diagnostic status block.
// Assumes lsd_mcu_model as serial controller and the bound checker.
module tb_lsd_diag_status import lsd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, sclk, cs_n, mosi, miso, miso_oe;
  logic       sup, hot, tgt, en, reg_en, gsw, smp, d2w;
  logic [2:0] cur, r, hr;
  lsd_chan_t  chan;
  logic [7:0] tcode, d2;
  logic [15:0] rep;
  int         num_errors, cmp_count, d2w_cnt, n;
  logic [6:0] addrs [4] = '{7'h00, 7'h06, 7'h26, 7'h36};

  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk) if (d2w === 1'b1) d2w_cnt++;

  lsd_diag_status #(.STARTUP_ERR_CYCLES(20), .OPER_ERR_CYCLES(5)) DUT (
    .core_clk_in(clk), .reset_in(rst), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
    .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .supply_above_uv_in(sup), .overtemp_in(hot),
    .gate_supply_at_target_in(tgt), .enable_in(en), .chan_in(chan), .temp_code_in(tcode), .diag2_in(d2),
    .regulator_enable_out(reg_en), .gate_switch_enable_out(gsw), .current_enable_out(cur),
    .led_voltage_sample_update_out(smp), .diag2_write_out(d2w));
  lsd_mcu_model mcu (.core_clk_in(clk), .spi_miso_in(miso), .spi_miso_oe_in(miso_oe),
    .spi_sclk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi));

  // Expected current-hit bits
  function automatic logic [7:0] hit_exp(logic [2:0] live, logic [2:0] low, logic ok);
    return ok ? {5'h00, live & ~low} : 8'h00;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic fr(input logic wr, input logic [6:0] a, input logic [7:0] d);
    mcu.xfer({16'h0000, wr, a, d}, 16, rep);
  endtask
  // Reply of the second frame carries the first frame's read value
  task automatic rd(input logic [6:0] a);
    fr(1'b0, a, 8'h00);
    fr(1'b0, 7'h37, 8'h00);
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask

  // Watchdog sized well above the planned run
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end

  initial begin
    d2 = 8'($urandom(32'hA74AB7BE));
    tcode = 8'($urandom);
    rst = 1'b1; sup = 1'b1; hot = 1'b0; tgt = 1'b1; en = 1'b1;
    chan = '0;
    chan.pwm = 3'h7;
    idle(4);
    rst = 1'b0;
    idle(60);
    // Reset values and read-only places
    for (int k = 0; k < 4; k++) begin
      rd(addrs[k]);
      check("no err", rep[15:8] & 8'h40, 8'h00);
      if (rep[14] === 1'b0)
        check("reg", rep[7:0], k == 0 ? 8'h8E : k == 1 ? 8'h00 : k == 2 ? tcode : d2);
    end
    rd(7'h37);
    check("status", rep[7:0], 8'h88);
    check("current", 8'(cur), 8'h07);
    n = d2w_cnt;
    fr(1'b1, 7'h36, 8'h00);
    idle(2);
    check("d2 write", 8'(d2w_cnt - n), 8'h01);
    // Each refused access: flag, forced reply, discard, clear
    for (int k = 0; k < 4; k++) begin
      n = d2w_cnt;
      case (k)
        0: fr(1'b0, 7'h10, 8'h00);
        1: fr(1'b1, 7'h26, 8'($urandom));
        2: fr(1'b1, 7'h50, 8'h00);
        default: mcu.xfer({15'h0000, 1'b1, 1'b1, 7'h36, 8'hA5}, 17, rep);
      endcase
      fr(1'b0, 7'h00, 8'h00);
      check("err flag", rep[15:8] & 8'h40, 8'h40);
      check("err data", rep[7:0], d2);
      check("discard", 8'(d2w_cnt - n), 8'h00);
      fr(1'b1, 7'h37, 8'h00);
      // Replies of the clearing write and of the frame after it still show the flag; look two frames later
      rd(7'h37);
      check("err clear", rep[15:8] & 8'h40, 8'h00);
    end
    // Copy requests and edge loads with random channels
    for (int k = 0; k < 3; k++) begin
      r = 3'($urandom);
      hr = 3'($urandom);
      chan.reached = r;
      idle(8);
      chan.reached = 3'h0;
      fr(1'b1, 7'h06, 8'h07);
      rd(7'h37);
      check("hit copy", rep[7:0] & 8'h07, hit_exp(r, 3'h0, 1'b1));
      fr(1'b1, 7'h06, 8'h07);
      rd(7'h37);
      check("live cleared", rep[7:0] & 8'h07, 8'h00);
      chan.reached = r;
      idle(8);
      chan.pwm = 3'h0;
      idle(8);
      chan.pwm = 3'h7;
      chan.reached = 3'h0;
      chan.headroom_low = hr;
      idle(8);
      chan.headroom_low = 3'h0;
      rd(7'h37);
      check("hit pwm", rep[7:0] & 8'h07, hit_exp(r, hr, 1'b1));
    end
    sup = 1'b0;
    idle(8);
    check("uv off", {cur, reg_en, smp}, 8'h00);
    rd(7'h37);
    check("uv status", rep[7:0] & 8'h8F, hit_exp(r, 3'h0, 1'b0));
    sup = 1'b1;
    idle(60);
    // Overtemp latches and needs the clear command
    // Long enough with the link quiet for the latch checker to see it
    hot = 1'b1;
    idle(16);
    rd(7'h37);
    check("hot", rep[7:0] & 8'h38, 8'h30);
    hot = 1'b0;
    rd(7'h37);
    check("hot held", rep[7:0] & 8'h38, 8'h30);
    fr(1'b1, 7'h00, 8'h4E);
    idle(60);
    rd(7'h37);
    check("hot clear", rep[7:0] & 8'h38, 8'h08);
    // Gate supply drops out of target while running
    tgt = 1'b0;
    idle(40);
    rd(7'h37);
    check("gate fault", rep[7:0] & 8'h18, 8'h10);
    check("gate off", 8'(cur), 8'h00);
    tgt = 1'b1;
    en = 1'b0;
    idle(8);
    en = 1'b1;
    idle(60);
    rd(7'h37);
    check("fault clear", rep[7:0] & 8'h18, 8'h08);
    // Second reset in mid-run
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    idle(60);
    rd(7'h37);
    check("reset status", rep[7:0], 8'h88);
    conclude();
  end
endmodule // tb_lsd_diag_status
